/* rtl/tgo_pin_sync.sv */
`default_nettype none
module tgo_pin_sync #(
  parameter int unsigned W = 4
)(
  input  wire logic         clk,   // Core clock
  input  wire logic         nrst,  // Async reset, active low
  input  wire logic [W-1:0] pins,  // Asynchronous pin levels
  output logic      [W-1:0] lvl,   // Filtered level
  output logic      [W-1:0] rise   // One-cycle rising edge
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ==========================================================
  // Three-stage capture, level moves once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1  <= '0;
      s2  <= '0;
      s3  <= '0;
      lvl <= '0;
    end else begin
      s1  <= pins;
      s2  <= s1;
      s3  <= s2;
      lvl <= (s2 & s3) | (lvl & (s2 | s3));
    end
  end

  // Edge when both late stages are high and level still low
  assign rise = s2 & s3 & ~lvl;
endmodule : tgo_pin_sync
`default_nettype wire

/* rtl/tgo_pkg.sv */
`default_nettype none
package tgo_pkg;
  // ==========================================================
  // Register map: word indices, byte address is four times index
  localparam int unsigned ADDR_W      = 11;
  localparam logic [8:0]  IDX_BITCODE = 9'h163;
  localparam logic [8:0]  IDX_GAPSEL1 = 9'h164;
  localparam logic [8:0]  IDX_GAPSEL2 = 9'h165;
  localparam logic [8:0]  IDX_GAPSEL3 = 9'h166;
  localparam logic [8:0]  IDX_GAPSEL4 = 9'h167;
  localparam logic [8:0]  IDX_DLBYTE  = 9'h168;
  localparam logic [8:0]  IDX_ESTORE  = 9'h169;
  localparam logic [8:0]  IDX_CTL2    = 9'h16a;
  localparam logic [8:0]  IDX_STATUS  = 9'h16b;
  localparam logic [8:0]  IDX_MASK    = 9'h16c;
  localparam logic [8:0]  IDX_MSG1    = 9'h16d;
  localparam logic [8:0]  IDX_MSG2    = 9'h16e;
  localparam logic [8:0]  IDX_MSG3    = 9'h16f;
  // ==========================================================
  // Field positions
  localparam int unsigned ES_ENABLE  = 0;
  localparam int unsigned ES_GAPEN   = 6;
  localparam int unsigned ES_FMT56   = 7;
  localparam int unsigned C2_E1      = 0;
  localparam int unsigned C2_D4      = 1;
  localparam int unsigned C2_CARRIER = 2;
  localparam int unsigned C2_BP2048  = 3;
  localparam int unsigned C2_DLREG   = 4;
  localparam int unsigned C2_MSGPIN  = 5;
  localparam int unsigned C2_SENDBOC = 6;
  localparam int unsigned C2_FPASS   = 7;
  localparam int unsigned ST_DLEMPTY = 0;
  localparam int unsigned ST_MSGSENT = 1;
  localparam int unsigned PIN_NET    = 0;
  localparam int unsigned PIN_BP     = 1;
  localparam int unsigned PIN_SER    = 2;
  localparam int unsigned PIN_DL     = 3;
  // ==========================================================
  // Reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  RST_DLBYTE = 8'h1c;
  // ==========================================================
  // Frame structure and patterns
  localparam logic [4:0]  LAST_CHAN_T1   = 5'h17;
  localparam logic [4:0]  LAST_CHAN_BP   = 5'h1f;
  localparam logic [2:0]  LAST_BIT       = 3'h7;
  localparam logic [2:0]  DC_BIT         = 3'h7;
  localparam logic [6:0]  FR_ESF         = 7'h18;
  localparam logic [6:0]  FR_D4          = 7'h0c;
  localparam logic [6:0]  FR_CARRIER     = 7'h48;
  localparam logic [2:0]  DL_LAST_ESF    = 3'h7;
  localparam logic [2:0]  DL_LAST_D4     = 3'h5;
  localparam logic [5:0]  ESF_FPS        = 6'h34;
  localparam logic [5:0]  D4_FT          = 6'h15;
  localparam logic [5:0]  FT_LEN         = 6'h06;
  localparam logic [11:0] CARRIER_ALIGN  = 12'he38;
  localparam logic [5:0]  ALIGN_LEN      = 6'h0c;
  localparam logic [7:0]  BOC_FLAG       = 8'hff;
endpackage : tgo_pkg
`default_nettype wire

/* rtl/tgo_timing.sv */
`default_nettype none
module tgo_timing
  import tgo_pkg::*;
(
  input  wire logic       clk,       // Core clock
  input  wire logic       nrst,      // Async reset, active low
  input  wire logic       noFbit,    // 256-bit frames without F bit
  input  wire logic [6:0] frameMod,  // Frames per multiframe
  tgo_timing_if.src       tm         // Frame position out
);
  logic lastChan;

  // A channel past the last one after a mode change also ends the frame
  assign lastChan = tm.chan >= (noFbit ? LAST_CHAN_BP : LAST_CHAN_T1);

  // ==========================================================
  // Advance one bit on each selected line clock edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tm.fBit      <= 1'b1;
      tm.bitInChan <= 3'h0;
      tm.chan      <= 5'h00;
      tm.frame     <= 7'h00;
    end else if (tm.tick) begin
      if (tm.fBit) begin
        tm.fBit      <= 1'b0;
        tm.bitInChan <= 3'h0;
        tm.chan      <= 5'h00;
      end else if (tm.bitInChan != LAST_BIT) begin
        tm.bitInChan <= tm.bitInChan + 3'h1;
      end else begin
        tm.bitInChan <= 3'h0;
        tm.chan      <= lastChan ? 5'h00 : tm.chan + 5'h01;
        if (lastChan) begin
          tm.fBit  <= !noFbit;
          tm.frame <= (tm.frame >= frameMod - 7'h01) ? 7'h00 : tm.frame + 7'h01;
        end
      end
    end
  end
endmodule : tgo_timing
`default_nettype wire

/* rtl/tgo_timing_if.sv */
`default_nettype none
// ==========================================================
// Position of the current bit within the outgoing frame
interface tgo_timing_if;
  logic       tick;
  logic       fBit;
  logic [2:0] bitInChan;
  logic [4:0] chan;
  logic [6:0] frame;
  modport src (input tick, output fBit, output bitInChan, output chan, output frame);
  modport snk (input tick, input fBit, input bitInChan, input chan, input frame);
endinterface : tgo_timing_if
`default_nettype wire

/* rtl/tgo_tx_overhead.sv */
// Summary of operation
// - Gapped clock enable puts a gated clock on the channel clock output.
// - Thirty-two channel select bits; one gives clocks, zero suppresses them.
// - Clock follows network clock, or backplane clock with elastic store on.
// - 56k format drops the last channel bit clock; 64k clocks all eight.
// - With 2.048 MHz backplane, fourth select register is ordinary channel selects.
// - With 1.544 MHz backplane, fourth register bit 0 clocks F bit.
// - Bit-oriented code generator works in T1 ESF mode only.
// - Code register holds six bits, bit 0 least significant.
// - Send-code bit starts code insertion at once, repeating while set.
// - Datalink source sends register bits as FDL in ESF, Fs in D4.
// - Datalink byte is serialised least significant bit first.
// - After eight bits (six in D4) set datalink-empty; interrupt low when mask allows.
// - Unrewritten datalink byte is sent again; software has 2 ms in ESF, 1.5 ms in D4.
// - No zero stuffing on datalink register data.
// - D4 uses lower six datalink bits only.
// - Carrier multiframe is 72 frames: 36 Ft, 36 Fs positions.
// - Device inserts 12-bit alignment; rest from three message registers.
// - Message-sent set after each multiframe; old messages repeat if unwritten.
// - Format bit zero means 64k, one means 56k.
`default_nettype none
module tgo_tx_overhead
  import tgo_pkg::*;
(
  input  wire logic              clk,              // Core clock, 125 MHz
  input  wire logic              nrst,             // Async reset, active low
  input  wire logic              psel,             // APB select
  input  wire logic              penable,          // APB access phase
  input  wire logic              pwrite,           // APB write
  input  wire logic [ADDR_W-1:0] paddr,            // APB byte address
  input  wire logic [31:0]       pwdata,           // APB write data
  output logic      [31:0]       prdata,           // APB read data
  output logic                   pready,           // APB ready
  output logic                   pslverr,          // APB unmapped access
  input  wire logic              txNetworkClock,   // Network transmit clock pin
  input  wire logic              txBackplaneClock, // Backplane system clock pin
  input  wire logic              txSerialIn,       // Transmit serial data pin
  input  wire logic              txDatalinkPin,    // External message data pin
  output logic                   txLineData,       // Outgoing T1 stream
  output logic                   txChanClockOut,   // Channel or gapped clock
  output logic                   irqN              // Interrupt, active low
);
  tgo_timing_if tm ();

  logic [5:0]  bitcodeR;
  logic [7:0]  gapSelR [4];
  logic [7:0]  dlByteR;
  logic [7:0]  estoreR;
  logic [7:0]  ctl2R;
  logic [1:0]  statusR;
  logic [1:0]  maskR;
  logic [7:0]  msgR [3];
  logic [8:0]  wa;
  logic        wrEn;
  logic [7:0]  rdByte;
  logic [3:0]  lvl;
  logic [3:0]  rise;
  logic        noFbit;
  logic        d4;
  logic        carrier;
  logic        bocOn;
  logic [6:0]  frameMod;
  logic [2:0]  dlLast;
  logic [7:0]  dlShift;
  logic [2:0]  dlCnt;
  logic [3:0]  bocCnt;
  logic [15:0] bocWord;
  logic [23:0] msgShadow;
  logic [31:0] selAll;
  logic [5:0]  fsIdx;
  logic [2:0]  ftIdx;
  logic        fVal;
  logic        dlSlot;
  logic        bocSlot;
  logic        fDone;
  logic        mfEnd;
  logic        dlWrap;
  logic        gate;
  logic        clkLvl;
  logic [1:0]  stSet;
  logic [1:0]  stClr;

  // Word-aligned address inside the register window
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a[10:2] >= IDX_BITCODE) && (a[10:2] <= IDX_MSG3);
  endfunction : isMapped

  // ==========================================================
  // APB slave
  assign wa      = paddr[10:2];
  assign wrEn    = psel & penable & pwrite & isMapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & !isMapped(paddr);

  // Read multiplexer, unused bits read as zero
  always_comb begin
    case (wa)
      IDX_BITCODE: rdByte = {2'h0, bitcodeR};
      IDX_GAPSEL1: rdByte = gapSelR[0];
      IDX_GAPSEL2: rdByte = gapSelR[1];
      IDX_GAPSEL3: rdByte = gapSelR[2];
      IDX_GAPSEL4: rdByte = gapSelR[3];
      IDX_DLBYTE:  rdByte = dlByteR;
      IDX_ESTORE:  rdByte = estoreR;
      IDX_CTL2:    rdByte = ctl2R;
      IDX_STATUS:  rdByte = {6'h00, statusR};
      IDX_MASK:    rdByte = {6'h00, maskR};
      IDX_MSG1:    rdByte = msgR[0];
      IDX_MSG2:    rdByte = msgR[1];
      IDX_MSG3:    rdByte = msgR[2];
      default:     rdByte = 8'h00;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= isMapped(paddr) ? {24'h000000, rdByte} : 32'h00000000;
    end
  end

  // Writable registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bitcodeR <= RST_BYTE[5:0];
      dlByteR  <= RST_DLBYTE;
      estoreR  <= RST_BYTE;
      ctl2R    <= RST_BYTE;
      maskR    <= RST_BYTE[1:0];
      for (int i = 0; i < 4; i++) begin
        gapSelR[i] <= RST_BYTE;
      end
      for (int i = 0; i < 3; i++) begin
        msgR[i] <= RST_BYTE;
      end
    end else if (wrEn) begin
      case (wa)
        IDX_BITCODE: bitcodeR   <= pwdata[5:0];
        IDX_GAPSEL1: gapSelR[0] <= pwdata[7:0];
        IDX_GAPSEL2: gapSelR[1] <= pwdata[7:0];
        IDX_GAPSEL3: gapSelR[2] <= pwdata[7:0];
        IDX_GAPSEL4: gapSelR[3] <= pwdata[7:0];
        IDX_DLBYTE:  dlByteR    <= pwdata[7:0];
        IDX_ESTORE:  estoreR    <= pwdata[7:0];
        IDX_CTL2:    ctl2R      <= pwdata[7:0];
        IDX_MASK:    maskR      <= pwdata[1:0];
        IDX_MSG1:    msgR[0]    <= pwdata[7:0];
        IDX_MSG2:    msgR[1]    <= pwdata[7:0];
        IDX_MSG3:    msgR[2]    <= pwdata[7:0];
        default:     ;
      endcase
    end
  end

  // ==========================================================
  // Status and interrupt
  assign stSet = {mfEnd, dlWrap};
  assign stClr = (psel && penable && pwrite && wa == IDX_STATUS) ? pwdata[1:0] : 2'h0;

  // write one clears, a new event wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      statusR <= 2'h0;
    end else begin
      statusR <= stSet | (statusR & ~stClr);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqN <= 1'b1;
    end else begin
      irqN <= ~|(statusR & maskR);
    end
  end

  // ==========================================================
  // Pin capture and frame timing
  tgo_pin_sync #(
    .W (4)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .pins ({txDatalinkPin, txSerialIn, txBackplaneClock, txNetworkClock}),
    .lvl  (lvl),
    .rise (rise)
  );

  // line clock follows elastic store selection
  assign clkLvl  = estoreR[ES_ENABLE] ? lvl[PIN_BP] : lvl[PIN_NET];
  assign tm.tick = estoreR[ES_ENABLE] ? rise[PIN_BP] : rise[PIN_NET];

  assign noFbit  = ctl2R[C2_BP2048] | ctl2R[C2_E1];
  assign carrier = ctl2R[C2_CARRIER];
  assign d4      = ctl2R[C2_D4] | carrier;
  assign frameMod = carrier ? FR_CARRIER : (d4 ? FR_D4 : FR_ESF);

  tgo_timing u_timing (
    .clk      (clk),
    .nrst     (nrst),
    .noFbit   (noFbit),
    .frameMod (frameMod),
    .tm       (tm.src)
  );

  // ==========================================================
  // F-bit overhead selection
  // code generator only in T1 mode
  assign bocOn   = ctl2R[C2_SENDBOC] & !ctl2R[C2_E1];
  assign bocWord = {BOC_FLAG, 1'b0, bitcodeR, 1'b0};
  assign dlLast  = d4 ? DL_LAST_D4 : DL_LAST_ESF;
  assign fsIdx   = tm.frame[6:1];
  assign ftIdx   = 3'(fsIdx % FT_LEN);
  assign fDone   = tm.tick & tm.fBit & !noFbit;

  always_comb begin
    fVal    = lvl[PIN_SER];
    dlSlot  = 1'b0;
    bocSlot = 1'b0;
    if (!noFbit && !ctl2R[C2_FPASS]) begin
      if (!d4) begin
        if (!tm.frame[0]) begin
          if (bocOn) begin
            bocSlot = 1'b1;
            fVal    = bocWord[bocCnt];
          end else if (ctl2R[C2_DLREG]) begin
            dlSlot = 1'b1;
            fVal   = dlShift[dlCnt];
          end
        end else if (tm.frame[1]) begin
          fVal = ESF_FPS[tm.frame[4:2]];
        end
      end else if (!tm.frame[0]) begin
        fVal = D4_FT[ftIdx];
      end else if (carrier) begin
        if (fsIdx < ALIGN_LEN) begin
          fVal = CARRIER_ALIGN[fsIdx[3:0]];
        // message bits from the datalink pin
        end else if (ctl2R[C2_MSGPIN]) begin
          fVal = lvl[PIN_DL];
        end else begin
          fVal = msgShadow[5'(fsIdx - ALIGN_LEN)];
        end
      end else if (ctl2R[C2_DLREG]) begin
        dlSlot = 1'b1;
        fVal   = dlShift[dlCnt];
      end
    end
  end

  // sequence restarts when send-code is set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bocCnt <= 4'h0;
    end else if (!bocOn) begin
      bocCnt <= 4'h0;
    end else if (fDone && bocSlot) begin
      bocCnt <= bocCnt + 4'h1;
    end
  end

  // ==========================================================
  // Datalink serialiser, raw bits with no zero stuffing
  assign dlWrap = fDone & dlSlot & (dlCnt == dlLast);

  // LSB first; reload repeats old byte; no stuffing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dlShift <= RST_DLBYTE;
      dlCnt   <= 3'h0;
    end else if (fDone && dlSlot) begin
      if (dlCnt == dlLast) begin
        dlCnt   <= 3'h0;
        dlShift <= dlByteR;
      end else begin
        dlCnt <= dlCnt + 3'h1;
      end
    end
  end

  // message buffer reload at multiframe end
  assign mfEnd = fDone & carrier & (tm.frame == FR_CARRIER - 7'h01);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      msgShadow <= 24'h000000;
    end else if (mfEnd) begin
      msgShadow <= {msgR[2], msgR[1], msgR[0]};
    end
  end

  // Line data: overhead in F slot, serial input elsewhere
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txLineData <= 1'b0;
    end else begin
      txLineData <= tm.fBit ? fVal : lvl[PIN_SER];
    end
  end

  // ==========================================================
  // Channel clock output
  // all 32 selects usable with 256-bit frames
  assign selAll = {gapSelR[3], gapSelR[2], gapSelR[1], gapSelR[0]};

  always_comb begin
    // fourth register bit 0 gates F-bit clock
    if (tm.fBit) begin
      gate = !noFbit & gapSelR[3][0];
    end else begin
      // per-channel select; drop bit 8 in 56k
      gate = selAll[tm.chan] & !(estoreR[ES_FMT56] & (tm.bitInChan == DC_BIT));
    end
  end

  // gapped clock replaces the channel marker
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txChanClockOut <= 1'b0;
    end else if (estoreR[ES_GAPEN]) begin
      txChanClockOut <= gate & clkLvl;
    end else begin
      txChanClockOut <= clkLvl & !tm.fBit & (tm.bitInChan == 3'h0);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_dlWrap;
    fDone && dlSlot && (dlCnt == dlLast);
  endsequence

  a_gap_chan_mask: assert property (
    estoreR[ES_GAPEN] && !tm.fBit && !selAll[tm.chan] |=> !txChanClockOut)
    else $error("Clock on unselected channel");
  a_gap_follow_clk: assert property (
    estoreR[ES_GAPEN] && gate |=> txChanClockOut == $past(clkLvl))
    else $error("Gapped clock not following line clock");
  a_gap_56k_omit: assert property (
    estoreR[ES_GAPEN] && estoreR[ES_FMT56] && !tm.fBit && tm.bitInChan == DC_BIT |=> !txChanClockOut)
    else $error("Clock on 56k control bit");
  a_fbit_clock_off: assert property (
    estoreR[ES_GAPEN] && tm.fBit && !gapSelR[3][0] |=> !txChanClockOut)
    else $error("Clock during F bit");
  a_boc_e1_off: assert property (
    ctl2R[C2_E1] |-> !bocSlot ##1 bocCnt == 4'h0)
    else $error("Code generator active in E1");
  a_dl_empty_set: assert property (
    s_dlWrap |=> statusR[ST_DLEMPTY] && dlShift == $past(dlByteR) && dlCnt == 3'h0)
    else $error("Datalink empty not raised");
  a_irq_masked: assert property (
    |(statusR & maskR) |=> !irqN ##1 (irqN == !(|($past(statusR) & $past(maskR)))))
    else $error("Interrupt does not follow mask");
  a_msg_sent_set: assert property (
    mfEnd |=> statusR[ST_MSGSENT] && msgShadow == {$past(msgR[2]), $past(msgR[1]), $past(msgR[0])})
    else $error("Message sent not raised");
  a_status_sticky: assert property (
    statusR[ST_DLEMPTY] && !stClr[ST_DLEMPTY] |=> statusR[ST_DLEMPTY])
    else $error("Status bit lost without clear");
endmodule : tgo_tx_overhead
`default_nettype wire

/* testbench/t1_tx_overhead_and_gapped_clock_bench.sv */
`default_nettype none
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin errTotal++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module t1_tx_overhead_and_gapped_clock_bench
  import tgo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Signals
  logic              clk     = 1'b0;
  logic              nrst    = 1'b0;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [ADDR_W-1:0] paddr   = '0;
  logic [31:0]       pwdata  = '0;
  logic [31:0]       prdata;
  logic              pready, pslverr, netClk, bpClk, serIn, dlPin, lineData, chanClk, irqN;
  logic [32:0]       rdQ[$];
  logic [32:0]       rdExp;
  int                cntQ[$];
  int                errTotal = 0;
  int                testsRun = 0;
  int                nBits, cnt, k, cntExp, i;
  logic              fsQ[$];
  logic              lastF, fPh, fsExp;
  logic              useBp, ck, lastCk, lastOut;
  logic [7:0]        r;
  event              measure;

  // Core clock, 8 ns
  always #4 clk = ~clk;

  tgo_tx_overhead dut (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txNetworkClock(netClk), .txBackplaneClock(bpClk), .txSerialIn(serIn),
    .txDatalinkPin(dlPin), .txLineData(lineData), .txChanClockOut(chanClk), .irqN(irqN)
  );
  tgo_line_partner line (.netClk(netClk), .bpClk(bpClk), .serIn(serIn), .dlPin(dlPin));

  // ====================
  // Bus tasks
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [8:0] idx, input logic [7:0] wd);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    // Wait for pready; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Note the expected {pslverr, prdata}, then read
  task automatic rd(input logic [8:0] idx, input logic [32:0] e);
    rdQ.push_back(e);
    apb(1'b0, idx, 8'h00);
  endtask : rd

  // Program gapped clock setup and request one pulse count
  task automatic gap(input logic [7:0] es, c2, s1, s2, s4, input int bits, exp);
    apb(1'b1, IDX_ESTORE, es);
    apb(1'b1, IDX_CTL2, c2);
    apb(1'b1, IDX_GAPSEL1, s1);
    apb(1'b1, IDX_GAPSEL2, s2);
    apb(1'b1, IDX_GAPSEL4, s4);
    useBp = es[ES_ENABLE];
    nBits = bits;
    cntQ.push_back(exp);
    ->measure;
    wait (cntQ.size() == 0);
  endtask : gap

  // Print the verdict and stop
  task automatic summarize;
    if (errTotal == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // ====================
  // Monitors
  // Compare each completed read with the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rdQ.size() > 0) begin
      rdExp = rdQ.pop_front();
      `CHK("read", rdExp, {pslverr, prdata})
    end
  end

  // Count channel clock pulses over a whole number of line bits
  initial forever begin
    @(measure);
    lastCk  = 1'b1;
    lastOut = 1'b1;
    k       = 0;
    cnt     = 0;
    while (k <= nBits + 8) begin
      @(negedge clk);
      ck = useBp ? bpClk : netClk;
      if (ck && !lastCk) k++;
      if (chanClk === 1'b1 && !lastOut && k > 8) cnt++;
      lastCk  = ck;
      lastOut = chanClk;
    end
    cntExp = cntQ.pop_front();
    `CHK("pulses", cntExp, cnt)
  end

  // Every second F-bit clock carries an Fs bit; compare it with the oldest note
  always @(posedge clk) begin
    if (chanClk === 1'b1 && !lastF && fsQ.size() > 0) begin
      fPh = !fPh;
      if (!fPh) begin
        fsExp = fsQ.pop_front();
        `CHK("fs bit", fsExp, lineData)
      end
    end
    lastF = chanClk;
  end

  // Cut a hang short
  initial begin
    repeat (100000) @(posedge clk);
    errTotal++;
    summarize();
  end

  // ====================
  // Main sequence
  initial begin
    void'($urandom(32'h01cb));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // Reset values, then an unmapped word
    for (i = 0; i < 13; i++) rd(IDX_BITCODE + 9'(i), {25'h0, (i == 5) ? RST_DLBYTE : RST_BYTE});
    rd(9'h170, {1'b1, 32'h0});
    r = 8'($urandom());
    apb(1'b1, IDX_BITCODE, r);
    rd(IDX_BITCODE, {25'h0, r & 8'h3f});
    // Gapped clock: selects, formats, clock source, backplane modes
    gap(8'h40, 8'h00, 8'hff, r, 8'h00, 193, 64 + 8 * $countones(r));
    gap(8'hc0, 8'h00, 8'hff, 8'h00, 8'h00, 193, 56);
    gap(8'h40, 8'h00, 8'h00, 8'h00, 8'h01, 193, 1);
    gap(8'h41, 8'h00, 8'hff, 8'h00, 8'h00, 193, 64);
    gap(8'h40, 8'h08, 8'h00, 8'h00, 8'hff, 256, 64);
    gap(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 193, 24);
    // D4 Fs from the datalink byte, F-bit clock marks each frame
    r = 8'($urandom());
    r[7:6] = ~r[1:0];
    apb(1'b1, IDX_STATUS, 8'h03);
    apb(1'b1, IDX_MASK, 8'h01);
    apb(1'b1, IDX_ESTORE, 8'h40);
    apb(1'b1, IDX_GAPSEL4, 8'h01);
    apb(1'b1, IDX_DLBYTE, r);
    apb(1'b1, IDX_CTL2, 8'h12);
    while (irqN !== 1'b0) @(posedge clk);
    // Next Fs bits: low six bits LSB first, then the same byte again
    fPh = 1'b0;
    for (i = 0; i < 8; i++) fsQ.push_back(r[i % 6]);
    // empty flag and interrupt, write-one clear
    rd(IDX_STATUS, {25'h0, 8'h01});
    `CHK("irqN", 1'b0, irqN)
    apb(1'b1, IDX_STATUS, 8'h01);
    rd(IDX_STATUS, 33'h0);
    `CHK("irqN", 1'b1, irqN)
    wait (fsQ.size() == 0);
    // send-code set after the code write, with E1 mode on
    apb(1'b1, IDX_CTL2, 8'h41);
    rd(IDX_CTL2, {25'h0, 8'h41});
    summarize();
  end
endmodule : t1_tx_overhead_and_gapped_clock_bench
`default_nettype wire

/* testbench/tgo_line_partner.sv */
`default_nettype none
module tgo_line_partner (
  output logic netClk,  // Free-running line clock, 80 ns
  output logic bpClk,   // Backplane clock, 100 ns
  output logic serIn,   // Serial channel data
  output logic dlPin    // External message data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Clocks and data
  // Start all lines at a known level
  initial begin
    netClk = 1'b0;
    bpClk  = 1'b0;
    serIn  = 1'b0;
    dlPin  = 1'b0;
  end
  // Free-running clocks with unrelated periods
  always #40 netClk = ~netClk;
  always #50 bpClk = ~bpClk;
  // New data bit after each falling line clock edge
  always @(negedge netClk) begin
    serIn <= 1'($urandom());
    dlPin <= 1'($urandom());
  end
endmodule : tgo_line_partner
`default_nettype wire
